// *** hw/dpm_top.sv ***
// Purpose: power-down mode selection, host gating and refresh source control for the display controller
// Assumes: classic Wishbone slave, all pins synchronous to clk_i, ce_i freezes all state
// Notes: clock slowdown is reported on clk_div8_o for the clock generator to act on
`timescale 1ns/1ps
`default_nettype none
module dpm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic powerdown_request_pin_i,
    input wire logic reference_clock_in_i,
    input wire logic low_freq_refresh_in_i,
    input wire logic bus_refresh_n_i,
    input wire logic hretrace_i,
    input wire logic line_refresh_i,
    input wire logic panel_frame_pulse_i,
    input wire logic isa_cycle_i,
    output logic isa_oe_o,
    output logic host_access_en_o,
    output logic ram_access_en_o,
    output logic clk_div8_o,
    output logic self_refresh_o,
    output logic refresh_req_o,
    output logic panel_enable_n_o,
    output logic panel_off_out_o,
    output logic panel_tristate_o,
    output logic panel_aux_o,
    output dpm_pkg::dpm_mode_e mode_o
);
    import dpm_pkg::*;

    function automatic dpm_mode_e mode_sel(input logic [7:0] iv, input logic [7:0] cf);
        if (iv[DPM_INT_GENERAL_BIT])
            mode_sel = DPM_MODE_GENERAL;
        else if (cf[DPM_CFG_SLEEP_BIT])
            mode_sel = DPM_MODE_SLEEP;
        else
            mode_sel = DPM_MODE_IDLE;
    endfunction : mode_sel

    logic [7:0] powerdown_refresh_interval_reg;
    logic [7:0] powerdown_config_reg;
    logic [7:0] panel_tristate_reg;
    logic [7:0] panel_power_reg;
    logic [7:0] refresh_divider_reg;
    logic [7:0] refresh_count_reg;
    dpm_state_e state;
    dpm_mode_e mode;
    logic req_q;
    logic [1:0] hr_cnt;
    logic [1:0] rf_cnt;
    logic [1:0] fp_cnt;
    logic div8_on;

    dpm_refresh_if rif ();

    dpm_refresh_gen u_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .bus_refresh_n_i(bus_refresh_n_i),
        .reference_clock_in_i(reference_clock_in_i),
        .low_freq_refresh_in_i(low_freq_refresh_in_i),
        .rif(rif)
    );

    // mode sequencing
    wire req_fall = req_q && !powerdown_request_pin_i;
    wire req_rise = !req_q && powerdown_request_pin_i;
    wire low_mode = (state == DPM_ST_LOW);
    wire in_sleep = (state != DPM_ST_RUN) && (state != DPM_ST_WAKE) && (mode == DPM_MODE_SLEEP);
    // self-refresh only where the general interval timer is not in charge; decoded from config so
    // no alternate refresh slips out in the cycle before the self-refresh output rises
    wire self_ref_sel = (mode != DPM_MODE_GENERAL) && powerdown_config_reg[DPM_CFG_SELF_REF_BIT];
    wire host_block = in_sleep && powerdown_config_reg[DPM_CFG_RELEASE_BIT];
    wire enter_done = (hr_cnt >= DPM_ENTER_COUNT) && (rf_cnt >= DPM_ENTER_COUNT);
    wire div8_req = (mode != DPM_MODE_GENERAL) || powerdown_config_reg[DPM_CFG_DIV8_BIT];

    // register bus decode
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire wr_commit = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire hit_int = (wb_adr_i == DPM_OFF_INTERVAL);
    wire hit_cfg = (wb_adr_i == DPM_OFF_CONFIG);
    wire hit_tri = (wb_adr_i == DPM_OFF_TRISTATE);
    wire hit_pwr = (wb_adr_i == DPM_OFF_PANEL_PWR);
    wire hit_div = (wb_adr_i == DPM_OFF_DIVIDER);
    wire hit_cnt = (wb_adr_i == DPM_OFF_REF_COUNT);
    wire hit_sts = (wb_adr_i == DPM_OFF_STATUS);
    // panel and divider registers stay open while sleep blocks the rest
    wire open_in_sleep = hit_tri || hit_pwr || hit_div;
    wire allowed = !host_block || open_in_sleep;
    wire [7:0] status_byte = {1'b0, state, mode, div8_on, rif.alt_en, panel_enable_n_o};
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_int)
            rd_byte = powerdown_refresh_interval_reg;
        if (hit_cfg)
            rd_byte = powerdown_config_reg;
        if (hit_tri)
            rd_byte = panel_tristate_reg;
        if (hit_pwr)
            rd_byte = panel_power_reg;
        if (hit_div)
            rd_byte = refresh_divider_reg;
        if (hit_cnt)
            rd_byte = refresh_count_reg;
        if (hit_sts)
            rd_byte = status_byte;
        if (!allowed)
            rd_byte = 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            powerdown_refresh_interval_reg <= DPM_RST_INTERVAL;
            powerdown_config_reg <= DPM_RST_CONFIG;
            panel_tristate_reg <= DPM_RST_TRISTATE;
            panel_power_reg <= DPM_RST_PANEL_PWR;
            refresh_divider_reg <= DPM_RST_DIVIDER;
            refresh_count_reg <= DPM_RST_REF_COUNT;
        end
        else if (ce_i && wr_commit && allowed)
        begin
            if (hit_int)
                powerdown_refresh_interval_reg <= wb_dat_i[7:0];
            if (hit_cfg)
                powerdown_config_reg <= wb_dat_i[7:0];
            if (hit_tri)
                panel_tristate_reg <= wb_dat_i[7:0];
            if (hit_pwr)
                panel_power_reg <= wb_dat_i[7:0];
            if (hit_div)
                refresh_divider_reg <= wb_dat_i[7:0];
            if (hit_cnt)
                refresh_count_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= DPM_ST_RUN;
            mode <= DPM_MODE_IDLE;
            req_q <= 1'b1;
            hr_cnt <= 2'h0;
            rf_cnt <= 2'h0;
            fp_cnt <= 2'h0;
            div8_on <= 1'b0;
            panel_enable_n_o <= 1'b1;
        end
        else if (ce_i)
        begin
            req_q <= powerdown_request_pin_i;
            if (req_rise)
            begin
                // wake wins over any entry still in progress
                state <= DPM_ST_WAKE;
                div8_on <= 1'b0;
                fp_cnt <= 2'h0;
            end
            else
            begin
                unique case (state)
                    DPM_ST_RUN:
                    begin
                        panel_enable_n_o <= 1'b0;
                        if (req_fall)
                        begin
                            state <= DPM_ST_ENTER;
                            mode <= mode_sel(powerdown_refresh_interval_reg, powerdown_config_reg);
                            panel_enable_n_o <= 1'b1;
                            hr_cnt <= 2'h0;
                            rf_cnt <= 2'h0;
                        end
                    end
                    DPM_ST_ENTER:
                    begin
                        if (hretrace_i && hr_cnt < DPM_ENTER_COUNT)
                            hr_cnt <= hr_cnt + 2'h1;
                        if (line_refresh_i && rf_cnt < DPM_ENTER_COUNT)
                            rf_cnt <= rf_cnt + 2'h1;
                        if (enter_done)
                        begin
                            state <= DPM_ST_LOW;
                            div8_on <= div8_req;
                        end
                    end
                    DPM_ST_LOW:
                        state <= DPM_ST_LOW;
                    DPM_ST_WAKE:
                    begin
                        // frame pulses count only once panel drive has resumed
                        if (panel_frame_pulse_i && !panel_tristate_reg[DPM_TRI_BIT])
                            fp_cnt <= fp_cnt + 2'h1;
                        if (fp_cnt >= DPM_WAKE_FP_COUNT)
                        begin
                            state <= DPM_ST_RUN;
                            panel_enable_n_o <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // refresh timer steering; normal refresh logic keeps DRAM alive outside the low state
    assign rif.alt_en = low_mode && !self_ref_sel;
    assign rif.gen_mode = (mode == DPM_MODE_GENERAL);
    assign rif.div8 = div8_on;
    assign rif.src = powerdown_config_reg[DPM_CFG_SRC_LSB +: 2];
    assign rif.divisor = refresh_divider_reg;
    assign rif.interval = powerdown_refresh_interval_reg[6:0];
    assign rif.burst = refresh_count_reg[1:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            isa_oe_o <= 1'b0;
            host_access_en_o <= 1'b1;
            ram_access_en_o <= 1'b1;
            clk_div8_o <= 1'b0;
            self_refresh_o <= 1'b0;
            refresh_req_o <= 1'b0;
            panel_off_out_o <= 1'b0;
            panel_tristate_o <= 1'b0;
            panel_aux_o <= 1'b0;
            mode_o <= DPM_MODE_IDLE;
        end
        else if (ce_i)
        begin
            // bus lines only driven for a claimed cycle, never in sleep or wake
            isa_oe_o <= isa_cycle_i && !in_sleep && (state != DPM_ST_WAKE);
            host_access_en_o <= !host_block;
            ram_access_en_o <= (state == DPM_ST_RUN) || (state == DPM_ST_ENTER);
            clk_div8_o <= div8_on && !req_rise;
            self_refresh_o <= low_mode && self_ref_sel;
            refresh_req_o <= rif.req;
            panel_off_out_o <= !panel_power_reg[DPM_PWR_OFF_BIT];
            panel_tristate_o <= panel_tristate_reg[DPM_TRI_BIT];
            panel_aux_o <= panel_power_reg[DPM_PWR_AUX_BIT];
            mode_o <= mode;
        end
    end
endmodule : dpm_top
`default_nettype wire

// *** hw/dpm_pkg.sv ***
// Purpose: shared constants and types for the display power-down mode control
// Assumes: 32-bit classic Wishbone register map, one 8-bit register per word
// Notes: offsets are byte addresses
package dpm_pkg;
    localparam logic [7:0] DPM_OFF_INTERVAL = 8'h00;
    localparam logic [7:0] DPM_OFF_CONFIG = 8'h04;
    localparam logic [7:0] DPM_OFF_TRISTATE = 8'h08;
    localparam logic [7:0] DPM_OFF_PANEL_PWR = 8'h0C;
    localparam logic [7:0] DPM_OFF_DIVIDER = 8'h10;
    localparam logic [7:0] DPM_OFF_REF_COUNT = 8'h14;
    localparam logic [7:0] DPM_OFF_STATUS = 8'h18;

    // interval register fields
    localparam int DPM_INT_GENERAL_BIT = 7;
    // configuration register fields
    localparam int DPM_CFG_SLEEP_BIT = 7;
    localparam int DPM_CFG_DIV8_BIT = 6;
    localparam int DPM_CFG_RELEASE_BIT = 5;
    localparam int DPM_CFG_SELF_REF_BIT = 2;
    localparam int DPM_CFG_SRC_LSB = 0;
    // panel registers
    localparam int DPM_TRI_BIT = 5;
    localparam int DPM_PWR_OFF_BIT = 2;
    localparam int DPM_PWR_AUX_BIT = 5;

    localparam logic [7:0] DPM_RST_INTERVAL = 8'h00;
    localparam logic [7:0] DPM_RST_CONFIG = 8'h00;
    localparam logic [7:0] DPM_RST_TRISTATE = 8'h00;
    localparam logic [7:0] DPM_RST_PANEL_PWR = 8'h04;
    localparam logic [7:0] DPM_RST_DIVIDER = 8'h01;
    localparam logic [7:0] DPM_RST_REF_COUNT = 8'h00;

    localparam logic [1:0] DPM_ENTER_COUNT = 2'h2;
    localparam logic [1:0] DPM_WAKE_FP_COUNT = 2'h2;
    localparam logic [6:0] DPM_INTERVAL_ADD = 7'h05;
    localparam int DPM_DOTS_PER_CHAR = 8;
    localparam int DPM_CLK_DIVIDE = 8;
    localparam logic [2:0] DPM_REF_CYCLE_CLKS = 3'h6;

    typedef enum logic [1:0] {DPM_SRC_BUS, DPM_SRC_DIV, DPM_SRC_PASS, DPM_SRC_LOWF} dpm_src_e;
    typedef enum logic [1:0] {DPM_MODE_SLEEP, DPM_MODE_IDLE, DPM_MODE_GENERAL} dpm_mode_e;
    typedef enum logic [1:0] {DPM_ST_RUN, DPM_ST_ENTER, DPM_ST_LOW, DPM_ST_WAKE} dpm_state_e;
endpackage : dpm_pkg

// *** hw/dpm_refresh_if.sv ***
// Purpose: control and request bundle between the mode sequencer and refresh timer
// Assumes: single clock domain
// Notes: req is a one-cycle pulse per CAS-before-RAS refresh cycle
`timescale 1ns/1ps
`default_nettype none
interface dpm_refresh_if;
    logic alt_en;
    logic gen_mode;
    logic div8;
    logic [1:0] src;
    logic [7:0] divisor;
    logic [6:0] interval;
    logic [1:0] burst;
    logic req;
    modport ctl (output alt_en, output gen_mode, output div8, output src, output divisor,
        output interval, output burst, input req);
    modport gen (input alt_en, input gen_mode, input div8, input src, input divisor,
        input interval, input burst, output req);
endinterface : dpm_refresh_if
`default_nettype wire

// *** hw/dpm_refresh_gen.sv ***
// Purpose: timing source for refresh cycles while the display is powered down
// Assumes: reference and refresh inputs are synchronous to clk_i
// Notes: video clock slowdown is modelled by counting every eighth clock
`timescale 1ns/1ps
`default_nettype none
module dpm_refresh_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic bus_refresh_n_i,
    input wire logic reference_clock_in_i,
    input wire logic low_freq_refresh_in_i,
    dpm_refresh_if.gen rif
);
    import dpm_pkg::*;

    function automatic logic [11:0] period_of(input logic [6:0] iv);
        period_of = 12'(DPM_DOTS_PER_CHAR) * (12'(iv) + 12'(DPM_INTERVAL_ADD));
    endfunction : period_of

    function automatic logic [2:0] cycles_of(input logic [1:0] b);
        cycles_of = (b == 2'h3) ? 3'h5 : 3'(b + 2'h1);
    endfunction : cycles_of

    logic ref_q, lf_q, bus_q;
    logic [2:0] slow_cnt;
    logic [7:0] div_cnt;
    logic [11:0] per_cnt;
    logic [2:0] burst_left;
    logic [2:0] gap_cnt;
    logic req;

    wire ref_rise = reference_clock_in_i && !ref_q;
    wire lf_rise = low_freq_refresh_in_i && !lf_q;
    wire bus_fall = !bus_refresh_n_i && bus_q;
    wire vtick = !rif.div8 || (slow_cnt == 3'(DPM_CLK_DIVIDE - 1));
    wire div_hit = ref_rise && (div_cnt <= 8'h01);
    wire per_hit = vtick && (per_cnt >= period_of(rif.interval) - 12'h001);
    wire burst_fire = (burst_left != 3'h0) && (gap_cnt == 3'h0);
    logic src_pulse;

    always_comb
    begin
        unique case (dpm_src_e'(rif.src))
            DPM_SRC_BUS: src_pulse = bus_fall;
            DPM_SRC_DIV: src_pulse = div_hit;
            DPM_SRC_PASS: src_pulse = ref_rise;
            DPM_SRC_LOWF: src_pulse = lf_rise;
        endcase
    end

    wire next_req = rif.alt_en && (rif.gen_mode ? burst_fire : src_pulse);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_q <= 1'b0;
            lf_q <= 1'b0;
            bus_q <= 1'b1;
            slow_cnt <= 3'h0;
            div_cnt <= 8'h00;
            per_cnt <= 12'h000;
            burst_left <= 3'h0;
            gap_cnt <= 3'h0;
            req <= 1'b0;
        end
        else if (ce_i)
        begin
            ref_q <= reference_clock_in_i;
            lf_q <= low_freq_refresh_in_i;
            bus_q <= bus_refresh_n_i;
            slow_cnt <= slow_cnt + 3'h1;
            if (ref_rise)
                div_cnt <= div_hit ? rif.divisor : div_cnt - 8'h01;
            // operation spacing in video clocks, slowed only when div8 is set, dots per char times interval plus five
            if (!rif.alt_en || !rif.gen_mode)
                per_cnt <= 12'h000;
            else if (vtick)
                per_cnt <= per_hit ? 12'h000 : per_cnt + 12'h001;
            if (rif.alt_en && rif.gen_mode && per_hit)
            begin
                burst_left <= cycles_of(rif.burst);
                gap_cnt <= 3'h0;
            end
            else if (burst_fire)
            begin
                burst_left <= burst_left - 3'h1;
                gap_cnt <= DPM_REF_CYCLE_CLKS - 3'h1;
            end
            else if (gap_cnt != 3'h0)
                gap_cnt <= gap_cnt - 3'h1;
            req <= next_req;
        end
    end

    assign rif.req = req;
endmodule : dpm_refresh_gen
`default_nettype wire

// *** verif/dpm_top_asserts.sv ***
// Purpose: port-level checks for the power-down mode control
// Assumes: ce_i held high, one clock domain
// Notes: bound into every dpm_top instance
`timescale 1ns/1ps
`default_nettype none
module dpm_top_asserts
    import dpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic powerdown_request_pin_i,
    input wire logic isa_oe_o,
    input wire logic host_access_en_o,
    input wire logic ram_access_en_o,
    input wire logic clk_div8_o,
    input wire logic self_refresh_o,
    input wire logic refresh_req_o,
    input wire logic panel_enable_n_o,
    input wire dpm_pkg::dpm_mode_e mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_release_sleep: assert property (!host_access_en_o |-> mode_o == DPM_MODE_SLEEP)
        else $error("host blocked outside sleep");
    a_isa_sleep: assert property (clk_div8_o && mode_o == DPM_MODE_SLEEP |-> !isa_oe_o)
        else $error("bus driven in sleep");
    a_reset_idle: assert property ($fell(rst_i) |-> !isa_oe_o && panel_enable_n_o && mode_o == DPM_MODE_IDLE)
        else $error("wrong state right after reset");
    a_div8_low: assert property ($rose(clk_div8_o) |-> !ram_access_en_o && !powerdown_request_pin_i)
        else $error("clock slowed outside low power");
    a_wake_clock: assert property ($rose(powerdown_request_pin_i) |-> ##[1:3] !clk_div8_o)
        else $error("clock not restored on wake");
    a_enable_drop: assert property ($fell(powerdown_request_pin_i) |-> ##[1:3] panel_enable_n_o)
        else $error("panel enable not released on request");
    a_enable_wake: assert property ($fell(panel_enable_n_o) |-> powerdown_request_pin_i && !clk_div8_o)
        else $error("panel enabled while powered down");
    a_refresh_alt: assert property (refresh_req_o |-> !self_refresh_o && !ram_access_en_o)
        else $error("alternate refresh outside low power");
    a_refresh_gap: assert property (refresh_req_o |=> !refresh_req_o)
        else $error("refresh request wider than one cycle");
    a_self_low: assert property (self_refresh_o |-> !ram_access_en_o)
        else $error("self refresh in normal operation");
endmodule : dpm_top_asserts

bind dpm_top dpm_top_asserts u_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .powerdown_request_pin_i, .isa_oe_o, .host_access_en_o, .ram_access_en_o, .clk_div8_o,
    .self_refresh_o, .refresh_req_o, .panel_enable_n_o, .mode_o);
`default_nettype wire

// *** verif/dpm_pm_model.sv ***
// Purpose: power manager and timing sources facing the mode control
// Assumes: outputs change just after clk_i rises
// Notes: edge counters let the bench predict refresh counts
`timescale 1ns/1ps
`default_nettype none
module dpm_pm_model (
    input wire logic clk_i,
    input wire logic sleep_cmd_i,
    output logic powerdown_request_pin_n_o,
    output logic ref_clk_o,
    output logic lowf_o,
    output logic bus_ref_n_o,
    output logic hretrace_o,
    output logic line_ref_o,
    output logic frame_o,
    output int ref_edges_o,
    output int lowf_edges_o,
    output int bus_pulses_o
);
    int tick = 0;
    initial
    begin
        {powerdown_request_pin_n_o, ref_clk_o, lowf_o, bus_ref_n_o} = 4'hD;
        {hretrace_o, line_ref_o, frame_o} = 3'h0;
        {ref_edges_o, lowf_edges_o, bus_pulses_o} = '0;
    end
    // sources keep running in every mode so refresh never starves
    always @(posedge clk_i)
    begin
        tick <= tick + 1;
        powerdown_request_pin_n_o <= !sleep_cmd_i;
        ref_clk_o <= tick[1];
        lowf_o <= (tick % 20) < 10;
        bus_ref_n_o <= (tick % 24) != 5;
        hretrace_o <= (tick % 16) == 3;
        line_ref_o <= (tick % 16) == 9;
        frame_o <= (tick % 40) == 0;
        ref_edges_o <= ref_edges_o + (tick[1:0] == 2'h2);
        lowf_edges_o <= lowf_edges_o + ((tick % 20) == 0);
        bus_pulses_o <= bus_pulses_o + ((tick % 24) == 5);
    end
endmodule : dpm_pm_model
`default_nettype wire

// *** verif/display_powerdown_mode_control_test.sv ***
// Purpose: self-checking bench for the power-down mode control
// Assumes: ce_i held high, refresh sources from the partner model
// Notes: refresh counts are compared with a tolerance of one burst in general mode, one pulse otherwise, none with self-refresh
`timescale 1ns/1ps
`default_nettype none
module display_powerdown_mode_control_test;
    import dpm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, isa_cycle_i = 1'b0, sleep_cmd = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, powerdown_request_pin_i, reference_clock_in_i, low_freq_refresh_in_i, bus_refresh_n_i;
    logic hretrace_i, line_refresh_i, panel_frame_pulse_i, isa_oe_o, host_access_en_o, ram_access_en_o;
    logic clk_div8_o, self_refresh_o, refresh_req_o, panel_enable_n_o, panel_off_out_o, panel_tristate_o;
    logic panel_aux_o;
    dpm_mode_e mode_o;
    int ref_edges, lowf_edges, bus_pulses, err_total = 0, total_checks = 0, cycles = 0, nrefresh = 0;
    logic [31:0] exp_q[$];
    logic [7:0] ivs [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h83};
    logic [7:0] cfgs [7] = '{8'hA0, 8'h01, 8'h02, 8'h83, 8'h04, 8'h40, 8'h00};

    dpm_top dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .powerdown_request_pin_i, .reference_clock_in_i, .low_freq_refresh_in_i,
        .bus_refresh_n_i, .hretrace_i, .line_refresh_i, .panel_frame_pulse_i, .isa_cycle_i, .isa_oe_o,
        .host_access_en_o, .ram_access_en_o, .clk_div8_o, .self_refresh_o, .refresh_req_o,
        .panel_enable_n_o, .panel_off_out_o, .panel_tristate_o, .panel_aux_o, .mode_o);
    dpm_pm_model u_pm (.clk_i(clk_i), .sleep_cmd_i(sleep_cmd), .powerdown_request_pin_n_o(powerdown_request_pin_i),
        .ref_clk_o(reference_clock_in_i), .lowf_o(low_freq_refresh_in_i), .bus_ref_n_o(bus_refresh_n_i),
        .hretrace_o(hretrace_i), .line_ref_o(line_refresh_i), .frame_o(panel_frame_pulse_i),
        .ref_edges_o(ref_edges), .lowf_edges_o(lowf_edges), .bus_pulses_o(bus_pulses));

    always #12.5 clk_i = ~clk_i;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    always @(posedge clk_i)
    begin
        cycles++;
        if (refresh_req_o === 1'b1)
            nrefresh++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            check(wb_dat_o, exp_q.pop_front());
        if (cycles == 30000)
        begin
            err_total++;
            $display("[ERR] t=%0t timeout cycles=%h limit=%h", $time, cycles, 30000);
            complete_run();
        end
    end

    // request held until the edge that samples ack, then released for a cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, dat};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        wb(1'b1, adr, dat, 4'h1);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        exp_q.push_back({24'h0, exp});
        wb(1'b0, adr, 8'h00, 4'h1);
    endtask : rd

    function automatic int events(input logic [1:0] s);
        return s == 2'h3 ? lowf_edges : s == 2'h0 ? bus_pulses : ref_edges;
    endfunction : events

    task automatic pd_cycle(input logic [7:0] iv, input logic [7:0] cfg);
        dpm_mode_e m;
        logic d8, blk;
        int r0, e0, ex, tol, fp, nb;
        m = iv[7] ? DPM_MODE_GENERAL : cfg[7] ? DPM_MODE_SLEEP : DPM_MODE_IDLE;
        d8 = !iv[7] || cfg[6];
        blk = m == DPM_MODE_SLEEP && cfg[5];
        nb = iv[1:0] == 2'h3 ? 5 : iv[1:0] + 1;
        tol = iv[7] ? nb : !cfg[2];
        wr(DPM_OFF_INTERVAL, iv);
        wr(DPM_OFF_CONFIG, cfg);
        wr(DPM_OFF_REF_COUNT, {6'h00, iv[1:0]});
        sleep_cmd <= 1'b1;
        isa_cycle_i <= 1'b1;
        for (int i = 0; i < 400 && ram_access_en_o !== 1'b0; i++)
            @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        check(mode_o, m);
        check(clk_div8_o, d8);
        check(panel_enable_n_o, 1'b1);
        check(isa_oe_o, m != DPM_MODE_SLEEP);
        check(self_refresh_o, cfg[2]);
        check(host_access_en_o, !blk);
        // host stays off the bus in sleep except to probe the release block
        if (blk)
        begin
            wr(DPM_OFF_INTERVAL, 8'h7F);
            rd(DPM_OFF_INTERVAL, 8'h00);
            rd(DPM_OFF_DIVIDER, 8'h03);
            wr(DPM_OFF_PANEL_PWR, 8'h20);
            rd(DPM_OFF_PANEL_PWR, 8'h20);
            check(panel_aux_o, 1'b1);
            wr(DPM_OFF_PANEL_PWR, DPM_RST_PANEL_PWR);
        end
        r0 = nrefresh;
        e0 = events(cfg[1:0]);
        repeat (1000) @(posedge clk_i);
        e0 = events(cfg[1:0]) - e0;
        ex = iv[7] ? nb * (1000 / (DPM_DOTS_PER_CHAR * (iv[6:0] + 5) * (d8 ? DPM_CLK_DIVIDE : 1))) : e0;
        ex = cfg[2] ? 0 : (!iv[7] && cfg[1:0] == 2'h1) ? e0 / 3 : ex;
        r0 = nrefresh - r0;
        check(r0 + tol >= ex && r0 <= ex + tol, 1'b1);
        sleep_cmd <= 1'b0;
        isa_cycle_i <= 1'($urandom);
        fp = 0;
        for (int i = 0; i < 600 && panel_enable_n_o !== 1'b0; i++)
        begin
            @(posedge clk_i);
            fp += panel_frame_pulse_i;
        end
        check(fp >= 2, 1'b1);
        check(clk_div8_o, 1'b0);
        if (blk)
            rd(DPM_OFF_INTERVAL, iv);
        $display("test powerdown iv=%h cfg=%h done", iv, cfg);
    endtask : pd_cycle

    initial
    begin
        logic [7:0] rv;
        void'($urandom(41));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(DPM_OFF_INTERVAL, DPM_RST_INTERVAL);
        rd(DPM_OFF_CONFIG, DPM_RST_CONFIG);
        rd(DPM_OFF_TRISTATE, DPM_RST_TRISTATE);
        rd(DPM_OFF_PANEL_PWR, DPM_RST_PANEL_PWR);
        rd(DPM_OFF_DIVIDER, DPM_RST_DIVIDER);
        rd(DPM_OFF_REF_COUNT, DPM_RST_REF_COUNT);
        rd(DPM_OFF_STATUS, 8'h08);
        rd(8'h1C, 8'h00);
        check({panel_off_out_o, panel_tristate_o, panel_aux_o, panel_enable_n_o}, 4'h0);
        $display("test reset values done");
        rv = 8'($urandom);
        wr(DPM_OFF_DIVIDER, rv);
        rd(DPM_OFF_DIVIDER, rv);
        wb(1'b1, DPM_OFF_DIVIDER, ~rv, 4'hE);
        rd(DPM_OFF_DIVIDER, rv);
        wr(DPM_OFF_DIVIDER, 8'h03);
        wr(DPM_OFF_TRISTATE, 8'h20);
        repeat (2) @(posedge clk_i);
        check(panel_tristate_o, 1'b1);
        wr(DPM_OFF_TRISTATE, 8'h00);
        $display("test register access done");
        for (int k = 0; k < 7; k++)
            pd_cycle(ivs[k], cfgs[k]);
        complete_run();
    end
endmodule : display_powerdown_mode_control_test
`default_nettype wire
